// [core/lba_format_regs.sv]
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module lba_format_regs
  import lba_format_pkg::*;
#(
  parameter int unsigned NUM_FORMATS = MAX_FORMATS
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // avalon-mm slave
  input  wire avmm_req_type i_bus,
  output avmm_rsp_type      o_bus,
  // format state to the data path
  output logic [FMT_W-1:0]  o_active_format,
  output meta_place_type    o_meta_place,
  output logic              o_active_unavailable
);
  localparam logic [FMT_W-1:0] LAST_INDEX = FMT_W'(NUM_FORMATS - 1);

  typedef struct packed {
    logic              waitrequest;
    logic [DATA_W-1:0] readdata;
    logic [1:0]        response;
    logic [FMT_W-1:0]  count;
    logic [FMT_W-1:0]  active;
    logic              ext;
    logic [1:0]        mc;
    logic              refused;
    meta_place_type    place;
    logic              unavail;
  } state_type;

  state_type        s;
  state_type        next_s;
  logic [IDX_W-1:0] idx;
  logic             access;
  logic             take;
  logic             commit;
  logic             wr_commit;
  logic [7:0]       wd;
  logic             in_table;
  logic [TBL_W-1:0] tbl_index;
  logic [FMT_W-1:0] tbl_entry;
  table_wr_type     tbl_wr;
  logic [7:0]       tbl_rd;
  logic [7:0]       act_ds;
  logic [15:0]      act_ms;
  logic             has_meta;
  logic             unsupported;
  logic [7:0]       status;
  logic [7:0]       rd_byte;
  logic             rd_hit;

  // bus decode
  assign idx       = i_bus.address[ADDR_W-1:2];
  assign access    = i_bus.read || i_bus.write;
  assign take      = access && s.waitrequest;
  assign commit    = access && !s.waitrequest;
  assign wr_commit = i_bus.write && commit && i_bus.byteenable[0];
  assign wd        = i_bus.writedata[7:0];
  assign in_table  = (idx >= IDX_TABLE_FIRST) && (idx <= IDX_TABLE_LAST);
  assign tbl_index = TBL_W'(idx - IDX_TABLE_FIRST);
  assign tbl_entry = tbl_index[TBL_W-1:2];

  assign tbl_wr.en    = wr_commit && in_table;
  assign tbl_wr.index = tbl_index;
  assign tbl_wr.data  = wd;

  lba_format_table #(
    .NUM_FORMATS (NUM_FORMATS)
  ) u_table (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_wr        (tbl_wr),
    .i_rd_index  (tbl_index),
    .i_count     (s.count),
    .i_active    (s.active),
    .o_rd_data   (tbl_rd),
    .o_active_ds (act_ds),
    .o_active_ms (act_ms)
  );

  // metadata placement checks
  assign has_meta    = (act_ms != 16'h0000);
  assign unsupported = has_meta && (s.ext ? !s.mc[MC_EXT_BIT] : !s.mc[MC_SEP_BIT]);

  always_comb begin
    status                  = 8'h00;
    status[ST_REFUSED_BIT]  = s.refused;
    status[ST_UNAVAIL_BIT]  = s.unavail;
    status[ST_UNSUPP_BIT]   = unsupported;
    status[ST_HAS_META_BIT] = has_meta;
    status[ST_SMALL_MS_BIT] = has_meta && (act_ms < MIN_MS_BYTES);
    status[ST_SMALL_DS_BIT] = (act_ds != DS_NONE) && (act_ds < MIN_DS_EXP);
  end

  // read mux, reserved bits zero
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (in_table) begin
      rd_byte = tbl_rd;
    end else begin
      case (idx)
        IDX_FORMAT_COUNT, IDX_CFG_COUNT: begin
          rd_byte = {4'h0, s.count};
        end
        IDX_ACTIVE_SELECT, IDX_CFG_ACTIVE: begin
          rd_byte = {3'h0, s.ext, s.active};
        end
        IDX_META_CAP, IDX_CFG_META_CAP: begin
          rd_byte = {6'h00, s.mc};
        end
        IDX_STATUS: begin
          rd_byte = status;
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    next_s             = s;
    next_s.waitrequest = !take;
    if (take) begin
      next_s.readdata = {24'h000000, rd_byte};
      next_s.response = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_commit) begin
      case (idx)
        IDX_CFG_COUNT: begin
          if ((wd > {4'h0, LAST_INDEX}) || (wd[FMT_W-1:0] < s.active)) begin
            next_s.refused = 1'b1;
          end else begin
            next_s.count   = wd[FMT_W-1:0];
            next_s.refused = 1'b0;
          end
        end
        IDX_CFG_ACTIVE: begin
          if (wd[FMT_W-1:0] > s.count) begin
            next_s.refused = 1'b1;
          end else begin
            next_s.active  = wd[FMT_W-1:0];
            next_s.ext     = wd[ACT_EXT_BIT];
            next_s.refused = 1'b0;
          end
        end
        IDX_CFG_META_CAP: begin
          next_s.mc      = wd[1:0];
          next_s.refused = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // one place only for the metadata
    if (!has_meta) begin
      next_s.place = META_NONE;
    end else if (s.ext) begin
      next_s.place = META_EXTENDED;
    end else begin
      next_s.place = META_SEPARATE;
    end
    next_s.unavail = (act_ds == DS_NONE);
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s             <= '0;
      s.waitrequest <= 1'b1;
      s.response    <= RESP_OKAY;
      s.count       <= RST_COUNT;
      s.active      <= RST_ACTIVE;
      s.ext         <= RST_EXT;
      s.mc          <= RST_MC;
      s.place       <= META_NONE;
      s.unavail     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_bus.waitrequest    = s.waitrequest;
  assign o_bus.readdata       = s.readdata;
  assign o_bus.response       = s.response;
  assign o_active_format      = s.active;
  assign o_meta_place         = s.place;
  assign o_active_unavailable = s.unavail;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_take(logic [IDX_W-1:0] a);
    i_bus.read && s.waitrequest && (idx == a);
  endsequence

  sequence s_commit_wr(logic [IDX_W-1:0] a);
    i_bus.write && !s.waitrequest && i_bus.byteenable[0] && (idx == a);
  endsequence

  sequence s_answer;
    !o_bus.waitrequest ##1 o_bus.waitrequest;
  endsequence

  a_bus_one_wait: assert property (
    (access && o_bus.waitrequest) |=> s_answer
  ) else $error("bus answer not after one wait cycle");

  a_count_limit: assert property (
    (s_commit_wr(IDX_CFG_COUNT) and (wd > {4'h0, LAST_INDEX})) |=> ($stable(s.count) && s.refused)
  ) else $error("format count above limit was accepted");

  a_count_taken: assert property (
    (s_commit_wr(IDX_CFG_COUNT) and (wd <= {4'h0, LAST_INDEX}) and (wd[FMT_W-1:0] >= s.active))
      |=> (s.count == $past(wd[FMT_W-1:0])) && !s.refused
  ) else $error("legal format count not stored");

  a_active_valid: assert property (
    o_active_format <= s.count
  ) else $error("active format beyond format count");

  a_table_zero: assert property (
    (i_bus.read && s.waitrequest && in_table && (tbl_entry > s.count)) |=> (o_bus.readdata == '0)
  ) else $error("invalid descriptor read as nonzero");

  a_table_read: assert property (
    (i_bus.read && s.waitrequest && in_table && (tbl_entry <= s.count))
      |=> (o_bus.readdata[7:0] == $past(tbl_rd)) && (o_bus.response == RESP_OKAY)
  ) else $error("descriptor read mismatch");

  a_unavail_flag: assert property (
    (act_ds == DS_NONE) |=> o_active_unavailable
  ) else $error("unavailable format not flagged");

  a_active_read: assert property (
    s_take(IDX_ACTIVE_SELECT) |=> (o_bus.readdata == {27'h0000000, $past(s.ext), $past(s.active)})
  ) else $error("active select readback wrong");

  a_place_ext: assert property (
    (s.ext && has_meta) |=> (o_meta_place == META_EXTENDED)
  ) else $error("extended placement not reported");

  a_place_sep: assert property (
    (!s.ext && has_meta) |=> (o_meta_place == META_SEPARATE)
  ) else $error("separate placement not reported");

  a_place_none: assert property (
    !has_meta |=> (o_meta_place == META_NONE)
  ) else $error("placement reported without metadata");

  a_mc_write: assert property (
    s_commit_wr(IDX_CFG_META_CAP) |=> (s.mc == $past(wd[1:0]))
  ) else $error("metadata capability write lost");

  a_mc_read: assert property (
    s_take(IDX_META_CAP) |=> (o_bus.readdata[1:0] == $past(s.mc))
  ) else $error("metadata capability readback wrong");

  a_mc_reserved: assert property (
    s_take(IDX_META_CAP) |=> (o_bus.readdata[DATA_W-1:2] == '0)
  ) else $error("capability reserved bits nonzero");

  a_count_reserved: assert property (
    s_take(IDX_FORMAT_COUNT) |=> (o_bus.readdata[DATA_W-1:FMT_W] == '0)
  ) else $error("count reserved bits nonzero");

  a_small_meta: assert property (
    (s_take(IDX_STATUS) and (has_meta && (act_ms < MIN_MS_BYTES))) |=> o_bus.readdata[ST_SMALL_MS_BIT]
  ) else $error("small metadata advisory missing");

  a_unmapped: assert property (
    (i_bus.read && s.waitrequest && !rd_hit) |=> (o_bus.response == RESP_SLVERR) && (o_bus.readdata == '0)
  ) else $error("unmapped read not answered with error");

  a_active_refused: assert property (
    (s_commit_wr(IDX_CFG_ACTIVE) and (wd[FMT_W-1:0] > s.count)) |=> ($stable(s.active) && s.refused)
  ) else $error("active index beyond count was accepted");

  a_active_taken: assert property (
    (s_commit_wr(IDX_CFG_ACTIVE) and (wd[FMT_W-1:0] <= s.count))
      |=> (s.active == $past(wd[FMT_W-1:0])) && (s.ext == $past(wd[ACT_EXT_BIT])) && !s.refused
  ) else $error("legal active select not stored");

  a_count_below: assert property (
    (s_commit_wr(IDX_CFG_COUNT) and (wd[FMT_W-1:0] < s.active)) |=> ($stable(s.count) && s.refused)
  ) else $error("count below active index was accepted");

  a_count_max: assert property (
    s.count <= LAST_INDEX
  ) else $error("format count above last index");

  a_count_read: assert property (
    s_take(IDX_FORMAT_COUNT) |=> (o_bus.readdata[FMT_W-1:0] == $past(s.count))
  ) else $error("format count readback wrong");

  a_ro_select: assert property (
    s_commit_wr(IDX_ACTIVE_SELECT) |=> ($stable(s.active) && $stable(s.ext))
  ) else $error("read-only active select was written");

  a_active_reserved: assert property (
    s_take(IDX_ACTIVE_SELECT) |=> (o_bus.readdata[DATA_W-1:ACT_EXT_BIT+1] == '0)
  ) else $error("active select reserved bits nonzero");

  a_avail_flag: assert property (
    (act_ds != DS_NONE) |=> !o_active_unavailable
  ) else $error("available format flagged unavailable");

  a_unavail_status: assert property (
    (s_take(IDX_STATUS) and s.unavail) |=> o_bus.readdata[ST_UNAVAIL_BIT]
  ) else $error("unavailable status bit missing");

  a_ext_unsupported: assert property (
    (s_take(IDX_STATUS) and (has_meta && s.ext && !s.mc[MC_EXT_BIT])) |=> o_bus.readdata[ST_UNSUPP_BIT]
  ) else $error("unsupported extended placement not flagged");

  a_sep_unsupported: assert property (
    (s_take(IDX_STATUS) and (has_meta && !s.ext && !s.mc[MC_SEP_BIT])) |=> o_bus.readdata[ST_UNSUPP_BIT]
  ) else $error("unsupported separate placement not flagged");

  a_be_ignored: assert property (
    (i_bus.write && !s.waitrequest && !i_bus.byteenable[0])
      |=> ($stable(s.count) && $stable(s.active) && $stable(s.mc))
  ) else $error("write without byte enable changed state");

  a_read_okay: assert property (
    (i_bus.read && s.waitrequest && rd_hit) |=> (o_bus.response == RESP_OKAY)
  ) else $error("mapped read answered with error");

  a_wait_idle: assert property (
    !access |=> o_bus.waitrequest
  ) else $error("answer without a request");
endmodule // lba_format_regs
`default_nettype wire

// [core/lba_format_pkg.sv]
`default_nettype none
package lba_format_pkg;
  // widths
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned BE_W        = DATA_W / 8;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned IDX_W       = ADDR_W - 2;
  localparam int unsigned FMT_W       = 4;
  localparam int unsigned TBL_W       = 6;
  localparam int unsigned MAX_FORMATS = 16;
  localparam int unsigned DESC_BYTES  = 4;
  // structure byte index, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FORMAT_COUNT  = 10'h019;
  localparam logic [IDX_W-1:0] IDX_ACTIVE_SELECT = 10'h01A;
  localparam logic [IDX_W-1:0] IDX_META_CAP      = 10'h01B;
  localparam logic [IDX_W-1:0] IDX_TABLE_FIRST   = 10'h080;
  localparam logic [IDX_W-1:0] IDX_TABLE_LAST    = 10'h0BF;
  localparam logic [IDX_W-1:0] IDX_CFG_COUNT     = 10'h100;
  localparam logic [IDX_W-1:0] IDX_CFG_ACTIVE    = 10'h101;
  localparam logic [IDX_W-1:0] IDX_CFG_META_CAP  = 10'h102;
  localparam logic [IDX_W-1:0] IDX_STATUS        = 10'h103;
  // field positions
  localparam int unsigned ACT_EXT_BIT     = 4;
  localparam int unsigned MC_EXT_BIT      = 0;
  localparam int unsigned MC_SEP_BIT      = 1;
  localparam int unsigned ST_REFUSED_BIT  = 0;
  localparam int unsigned ST_UNAVAIL_BIT  = 1;
  localparam int unsigned ST_UNSUPP_BIT   = 2;
  localparam int unsigned ST_HAS_META_BIT = 3;
  localparam int unsigned ST_SMALL_MS_BIT = 4;
  localparam int unsigned ST_SMALL_DS_BIT = 5;
  // descriptor byte positions
  localparam logic [1:0] DESC_MS_LO = 2'h0;
  localparam logic [1:0] DESC_MS_HI = 2'h1;
  localparam logic [1:0] DESC_DS    = 2'h2;
  // reset values and limits
  localparam logic [FMT_W-1:0] RST_COUNT     = 4'h0;
  localparam logic [FMT_W-1:0] RST_ACTIVE    = 4'h0;
  localparam logic             RST_EXT       = 1'h0;
  localparam logic [1:0]       RST_MC        = 2'h0;
  localparam logic [7:0]       DS_NONE       = 8'h00;
  localparam logic [7:0]       MIN_DS_EXP    = 8'h0C;
  localparam logic [15:0]      MIN_MS_BYTES  = 16'h0008;
  localparam logic [1:0]       RESP_OKAY     = 2'h0;
  localparam logic [1:0]       RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {META_NONE, META_EXTENDED, META_SEPARATE} meta_place_type;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } avmm_req_type;

  typedef struct packed {
    logic              waitrequest;
    logic [DATA_W-1:0] readdata;
    logic [1:0]        response;
  } avmm_rsp_type;

  typedef struct packed {
    logic             en;
    logic [TBL_W-1:0] index;
    logic [7:0]       data;
  } table_wr_type;
endpackage
`default_nettype wire

// [core/lba_format_table.sv]
`timescale 1ns/100ps
`default_nettype none
module lba_format_table
  import lba_format_pkg::*;
#(
  parameter int unsigned NUM_FORMATS = MAX_FORMATS
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // descriptor write
  input  wire table_wr_type     i_wr,
  // lookups
  input  wire logic [TBL_W-1:0] i_rd_index,
  input  wire logic [FMT_W-1:0] i_count,
  input  wire logic [FMT_W-1:0] i_active,
  output logic      [7:0]       o_rd_data,
  output logic      [7:0]       o_active_ds,
  output logic      [15:0]      o_active_ms
);
  localparam int unsigned NB = NUM_FORMATS * DESC_BYTES;

  typedef struct packed {
    logic [NB-1:0][7:0] bytes;
  } state_type;

  state_type        s;
  state_type        next_s;
  logic [FMT_W-1:0] rd_entry;
  logic [TBL_W-1:0] act_base;

  always_comb begin
    next_s = s;
    if (i_wr.en && (int'(i_wr.index) < NB)) begin
      next_s.bytes[i_wr.index] = i_wr.data;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_entry = i_rd_index[TBL_W-1:2];
  assign act_base = {i_active, 2'h0};

  // entries past the count read as zero
  always_comb begin
    o_rd_data = 8'h00;
    if ((rd_entry <= i_count) && (int'(i_rd_index) < NB)) begin
      o_rd_data = s.bytes[i_rd_index];
    end
    o_active_ds = s.bytes[act_base | TBL_W'(DESC_DS)];
    o_active_ms = {s.bytes[act_base | TBL_W'(DESC_MS_HI)], s.bytes[act_base | TBL_W'(DESC_MS_LO)]};
  end
endmodule // lba_format_table
`default_nettype wire

// [test/host_bus_model.sv]
`timescale 1ns/100ps
`default_nettype none
module host_bus_model
  import lba_format_pkg::*;
(
  // clock
  input  wire logic         i_clk,
  // avalon-mm master side
  input  wire avmm_rsp_type i_bus,
  output var avmm_req_type  o_bus
);
  initial o_bus = '0;

  // one transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr, input logic [7:0] wdata,
                      input logic [BE_W-1:0] be, output logic [DATA_W-1:0] rdata,
                      output logic [1:0] resp, output logic ok);
    avmm_req_type req;
    req            = '0;
    req.read       = !wr;
    req.write      = wr;
    req.address    = addr;
    req.writedata  = {24'h000000, wdata};
    req.byteenable = be;
    ok             = 1'b0;
    rdata          = '0;
    resp           = 2'h0;
    @(posedge i_clk);
    o_bus <= req;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge i_clk);
      if (i_bus.waitrequest === 1'b0) begin
        ok    = 1'b1;
        rdata = i_bus.readdata;
        resp  = i_bus.response;
        o_bus <= '0;
      end
    end
  endtask
endmodule // host_bus_model
`default_nettype wire

// [test/namespace_lba_format_descriptor_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("BAD %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module namespace_lba_format_descriptor_tb_top
  import lba_format_pkg::*;
;
  localparam int unsigned       FORMATS = 8;
  localparam logic [ADDR_W-1:0] A_CNT   = {IDX_FORMAT_COUNT, 2'b00};
  localparam logic [ADDR_W-1:0] A_ACT   = {IDX_ACTIVE_SELECT, 2'b00};
  localparam logic [ADDR_W-1:0] A_CAP   = {IDX_META_CAP, 2'b00};
  localparam logic [ADDR_W-1:0] C_CNT   = {IDX_CFG_COUNT, 2'b00};
  localparam logic [ADDR_W-1:0] C_ACT   = {IDX_CFG_ACTIVE, 2'b00};
  localparam logic [ADDR_W-1:0] C_CAP   = {IDX_CFG_META_CAP, 2'b00};
  localparam logic [ADDR_W-1:0] A_STAT  = {IDX_STATUS, 2'b00};

  logic             i_clk;
  logic             i_reset;
  avmm_req_type     bus_req;
  avmm_rsp_type     bus_rsp;
  logic [FMT_W-1:0] active_format;
  meta_place_type   meta_place;
  logic             active_unavailable;
  int               err_count;
  int               compares;
  logic [7:0]       acts   [4] = '{8'hF2, 8'h02, 8'h10, 8'h03};
  meta_place_type   places [4] = '{META_EXTENDED, META_SEPARATE, META_NONE, META_SEPARATE};
  logic             unav   [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic [7:0]       caps   [4] = '{8'h01, 8'h02, 8'hFF, 8'h00};

  lba_format_regs #(.NUM_FORMATS(FORMATS)) i_dut (
    .i_clk                (i_clk),
    .i_reset              (i_reset),
    .i_bus                (bus_req),
    .o_bus                (bus_rsp),
    .o_active_format      (active_format),
    .o_meta_place         (meta_place),
    .o_active_unavailable (active_unavailable)
  );

  host_bus_model i_host (
    .i_clk (i_clk),
    .i_bus (bus_rsp),
    .o_bus (bus_req)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic hang;
    err_count++;
    $display("BAD waitrequest expected 0 seen 1");
    stop_test();
  endtask

  task automatic wr_be(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] r;
    logic [1:0]        s;
    logic              ok;
    i_host.xfer(1'b1, a, d, be, r, s, ok);
    if (!ok) hang();
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    wr_be(a, d, 4'hF);
  endtask

  task automatic rd(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [DATA_W-1:0] r;
    logic [1:0]        s;
    logic              ok;
    i_host.xfer(1'b0, a, 8'h00, 4'hF, r, s, ok);
    if (!ok) hang();
    `CHK(what, {24'h000000, exp}, r)
    `CHK("read response", RESP_OKAY, s)
  endtask

  task automatic st(input string what, input int b, input logic v);
    logic [DATA_W-1:0] r;
    logic [1:0]        s;
    logic              ok;
    i_host.xfer(1'b0, A_STAT, 8'h00, 4'hF, r, s, ok);
    if (!ok) hang();
    `CHK(what, v, r[b])
  endtask

  function automatic logic [ADDR_W-1:0] desc(input int f, input logic [1:0] b);
    return {IDX_TABLE_FIRST + IDX_W'(4 * f) + IDX_W'(b), 2'b00};
  endfunction

  // placement and availability follow one edge after the answer, settle waits two
  task automatic settle;
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  initial begin
    logic [DATA_W-1:0] r;
    logic [1:0]        s;
    logic              ok;
    err_count = 0;
    compares  = 0;
    i_reset   = 1'b1;
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    // reset state
    rd("format count", A_CNT, 8'h00);
    rd("active select", A_ACT, 8'h00);
    rd("capability", A_CAP, 8'h00);
    st("unavailable flag", ST_UNAVAIL_BIT, 1'b1);
    `CHK("unavailable out", 1'b1, active_unavailable)
    `CHK("placement", META_NONE, meta_place)
    $display("test reset done");
    // format count limits, read-only and byte-enable
    wr(C_CNT, 8'(FORMATS - 1));
    rd("format count", A_CNT, 8'(FORMATS - 1));
    st("refused flag", ST_REFUSED_BIT, 1'b0);
    wr(C_CNT, 8'(FORMATS));
    st("refused flag", ST_REFUSED_BIT, 1'b1);
    wr(A_CNT, 8'h03);
    wr_be(C_CNT, 8'h02, 4'h0);
    rd("format count", A_CNT, 8'(FORMATS - 1));
    $display("test count done");
    // descriptor table, sizes per the recommended minimums
    for (int f = 0; f < FORMATS; f++) begin
      wr(desc(f, DESC_MS_LO), 8'(8 * f));
      wr(desc(f, DESC_DS), (f == 3) ? DS_NONE : MIN_DS_EXP);
    end
    for (int f = 0; f < FORMATS; f++) begin
      rd("meta size", desc(f, DESC_MS_LO), 8'(8 * f));
      rd("data size", desc(f, DESC_DS), (f == 3) ? DS_NONE : MIN_DS_EXP);
    end
    wr(C_CNT, 8'h02);
    rd("entry past count", desc(3, DESC_MS_LO), 8'h00);
    rd("entry past count", desc(7, DESC_DS), 8'h00);
    rd("last valid entry", desc(2, DESC_MS_LO), 8'h10);
    wr(C_ACT, 8'h03);
    st("refused flag", ST_REFUSED_BIT, 1'b1);
    rd("active select", A_ACT, 8'h00);
    $display("test table done");
    // active select and placement
    wr(C_ACT, 8'h02);
    wr(C_CNT, 8'h01);
    st("refused flag", ST_REFUSED_BIT, 1'b1);
    rd("format count", A_CNT, 8'h02);
    wr(C_CNT, 8'(FORMATS - 1));
    for (int i = 0; i < 4; i++) begin
      wr(C_ACT, acts[i]);
      rd("active select", A_ACT, acts[i] & 8'h1F);
      settle();
      `CHK("active format", acts[i][3:0], active_format)
      `CHK("placement", places[i], meta_place)
      `CHK("unavailable out", unav[i], active_unavailable)
    end
    $display("test active done");
    // capability bits against an extended format with metadata
    wr(C_ACT, 8'h12);
    for (int i = 0; i < 4; i++) begin
      wr(C_CAP, caps[i]);
      rd("capability", A_CAP, caps[i] & 8'h03);
      st("unsupported flag", ST_UNSUPP_BIT, !caps[i][MC_EXT_BIT]);
    end
    $display("test capability done");
    // advisory and separate-buffer status
    wr(desc(1, DESC_MS_LO), 8'h04);
    wr(desc(1, DESC_DS), 8'h09);
    wr(C_ACT, 8'h01);
    st("has metadata flag", ST_HAS_META_BIT, 1'b1);
    st("unsupported flag", ST_UNSUPP_BIT, 1'b1);
    st("small metadata flag", ST_SMALL_MS_BIT, 1'b1);
    st("small data flag", ST_SMALL_DS_BIT, 1'b1);
    settle();
    `CHK("placement", META_SEPARATE, meta_place)
    wr(C_ACT, 8'h00);
    st("has metadata flag", ST_HAS_META_BIT, 1'b0);
    st("small data flag", ST_SMALL_DS_BIT, 1'b0);
    $display("test advisory done");
    // unmapped read
    i_host.xfer(1'b0, 12'h800, 8'h00, 4'hF, r, s, ok);
    if (!ok) hang();
    `CHK("unmapped data", '0, r)
    `CHK("unmapped response", RESP_SLVERR, s)
    $display("test unmapped done");
    stop_test();
  end
endmodule // namespace_lba_format_descriptor_tb_top
`default_nettype wire
